// file: src/spm_pkg.sv
// How it works
// - Select codes 0-3 pick oscillator, references, aux detector
// - Codes 4-6 pick main detector, loop-back, test
// - Fractionality clear: main modulator runs 18 bits
// - Fractionality set: main modulator runs 10 bits
// - Aux power-down flag powers the aux synthesizer down
// - Aux mode flag selects integer-N for aux
// - No special power-up ordering is needed
// - Tri-state flag releases the select output pin
// - Chip-select length sets sample width 2-12
// - Offset applies to main synthesizer only
// - Magnitude m scales each sample by 2^m, with m held at 13 at most
// - Address-disable clear: 16-bit addressed transfers
// - Address-disable set: bare 2-12 bit samples
// - Samples accepted on either data pin
// - Latch on detector fall, forward next fall
// - Samples are two's complement signed
// - Sample is magnitude-scaled, then output as the main offset
// - Address then data, sampled on serial rise
// - Host may skip low dividend in 10-bit
package spm_pkg;
	// Link word layout
	localparam int           FRAME_BITS    = 16;
	localparam int           DATA_BITS     = 12;
	localparam int           SAMPLE_MIN    = 2;
	localparam int           SAMPLE_MAX    = 12;
	localparam logic [3:0]   ADDR_PWR_MUX  = 4'h5;
	localparam logic [3:0]   ADDR_MOD_CTRL = 4'h6;
	localparam logic [3:0]   ADDR_MOD_DATA = 4'h7;
	// Power and output select fields
	localparam int           PM_TEN_BIT    = 3;
	localparam int           PM_AUX_PD     = 4;
	localparam int           PM_AUX_INT    = 5;
	localparam int           PM_SEL_LO     = 6;
	localparam int           PM_SEL_HI     = 8;
	localparam int           PM_TRISTATE   = 9;
	// Modulation control fields
	localparam int           MC_MAG_HI     = 3;
	localparam int           MC_ADDR_DIS   = 4;
	localparam logic [3:0]   MAG_MAX       = 4'h000d;
	localparam int           OFFSET_BITS   = 25;
	// Modulator widths
	localparam logic [4:0]   DSM_WIDTH_FULL = 5'h0012;
	localparam logic [4:0]   DSM_WIDTH_TEN  = 5'h000a;
	// Reset values
	localparam logic [11:0]  PWR_MUX_RESET  = 12'h0000;
	localparam logic [11:0]  MOD_CTRL_RESET = 12'h0000;
	// Host register map
	localparam logic [11:0]  HOST_CMD_OFS    = 12'h0000;
	localparam logic [11:0]  HOST_STATUS_OFS = 12'h0004;
	localparam int           CMD_LEN_LO      = 16;
	localparam int           CMD_LEN_HI      = 20;
	localparam int           CMD_MODPIN      = 24;
	// Timing
	localparam int           CLK_PERIOD_NS  = 10;
	localparam int           LINK_PERIOD_NS = 160;
	localparam int           HALF_CYC       = LINK_PERIOD_NS / 2 / CLK_PERIOD_NS;
	localparam logic [3:0]   HALF_LAST      = 4'(HALF_CYC - 1);

	// Mux select codes
	typedef enum logic [2:0] {
		SEL_REF_OSC, SEL_REF_AUX, SEL_REF_MAIN, SEL_PD_AUX,
		SEL_PD_MAIN, SEL_LOOPBACK, SEL_TEST, SEL_UNUSED
	} spm_sel_e;
endpackage

// file: src/spm_link_if.sv
`timescale 1ns/1ns
// Three-wire write port plus alternate sample pin and the select output pin
interface spm_link_if;
	logic sclk;
	logic csn;
	logic sdata;
	logic mod_in;
	logic mux_out;
	logic mux_out_oe;

	modport device (input sclk, csn, sdata, mod_in, output mux_out, mux_out_oe);
	modport host   (output sclk, csn, sdata, mod_in, input mux_out, mux_out_oe);
endinterface

// file: src/spm_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser for a group of independent levels
module spm_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta     <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule

// file: src/spm_device.sv
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
// Device end: serial register writes, select output, modulation unit
module spm_device
	import spm_pkg::*;
(
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	spm_link_if.device                  link,
	input  wire logic                   ref_osc,
	input  wire logic                   ref_aux,
	input  wire logic                   ref_main,
	input  wire logic                   aux_phase_detector_clock,
	input  wire logic                   main_phase_detector_clock,
	output logic                        aux_power_down,
	output logic                        aux_integer_mode,
	output logic                        main_dsm_ten_bit,
	output logic [4:0]                  main_dsm_width,
	output logic signed [OFFSET_BITS-1:0] main_mod_offset,
	output logic                        main_mod_strobe
);
	// Sign-extend the low n bits of a sample to full width
	function automatic logic signed [DATA_BITS-1:0] sext(
		input logic [DATA_BITS-1:0] v,
		input logic [4:0]           n
	);
		logic [3:0]                  sh;
		logic signed [DATA_BITS-1:0] t;
		sh = 4'(DATA_BITS - 32'(n));
		t  = $signed(v << sh);
		return t >>> sh;
	endfunction

	// Scale a signed sample by 2^m, m held to its top value
	function automatic logic signed [OFFSET_BITS-1:0] scale(
		input logic signed [DATA_BITS-1:0] s,
		input logic [3:0]                  m
	);
		logic [3:0]                    mm;
		logic signed [OFFSET_BITS-1:0] w;
		mm = (m > MAG_MAX) ? MAG_MAX : m;
		w  = {{(OFFSET_BITS-DATA_BITS){s[DATA_BITS-1]}}, s};
		return w <<< mm;
	endfunction

	// Synchronised pins
	logic [8:0] sync_q;
	logic       s_sclk;
	logic       s_csn;
	logic       s_data;
	logic       s_mod;
	logic       s_ref_osc;
	logic       s_ref_aux;
	logic       s_ref_main;
	logic       s_pd_aux;
	logic       s_pd_main;

	spm_sync #(.W(9)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({link.sclk, link.csn, link.sdata, link.mod_in, ref_osc, ref_aux,
		            ref_main, aux_phase_detector_clock, main_phase_detector_clock}),
		.sync_out (sync_q)
	);

	assign {s_sclk, s_csn, s_data, s_mod, s_ref_osc, s_ref_aux,
	        s_ref_main, s_pd_aux, s_pd_main} = sync_q;

	// Registered state
	logic                        sclk_q;
	logic                        csn_q;
	logic                        pd_main_q;
	logic [FRAME_BITS-1:0]       shift;
	logic [4:0]                  bit_cnt;
	logic [DATA_BITS-1:0]        pwr_mux;
	logic [DATA_BITS-1:0]        mod_ctrl;
	logic signed [DATA_BITS-1:0] pend_sample;
	logic                        pend_valid;
	logic signed [DATA_BITS-1:0] unit_sample;
	logic                        unit_valid;

	// Edge and frame decode
	logic       sclk_rise;
	logic       frame_end;
	logic       pd_fall;
	logic       serial_bit;
	logic       addr_dis;
	logic       addressed;
	logic       bare_sample;
	logic [3:0] frame_addr;
	logic       wr_pwr;
	logic       wr_ctrl;
	logic       wr_data;

	assign sclk_rise   = s_sclk && !sclk_q && !s_csn;
	assign frame_end   = s_csn && !csn_q;
	assign pd_fall     = !s_pd_main && pd_main_q;
	assign serial_bit  = s_data | s_mod;
	assign addr_dis    = mod_ctrl[MC_ADDR_DIS];
	assign addressed   = frame_end && (bit_cnt == 5'(FRAME_BITS));
	assign bare_sample = frame_end && addr_dis && (bit_cnt >= 5'(SAMPLE_MIN))
	                     && (bit_cnt <= 5'(SAMPLE_MAX));
	assign frame_addr  = shift[FRAME_BITS-1:DATA_BITS];
	assign wr_pwr      = addressed && (frame_addr == ADDR_PWR_MUX);
	assign wr_ctrl     = addressed && (frame_addr == ADDR_MOD_CTRL);
	assign wr_data     = addressed && (frame_addr == ADDR_MOD_DATA);

	// Select output source
	logic next_mux_out;
	always_comb
	begin
		unique case (spm_sel_e'(pwr_mux[PM_SEL_HI:PM_SEL_LO]))
			SEL_REF_OSC:  next_mux_out = s_ref_osc;
			SEL_REF_AUX:  next_mux_out = s_ref_aux;
			SEL_REF_MAIN: next_mux_out = s_ref_main;
			SEL_PD_AUX:   next_mux_out = s_pd_aux;
			SEL_PD_MAIN:  next_mux_out = s_pd_main;
			SEL_LOOPBACK: next_mux_out = serial_bit;
			SEL_TEST:     next_mux_out = sclk_rise;
			SEL_UNUSED:   next_mux_out = 1'b0;
		endcase
	end

	// Edge history and bit shifter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_q    <= 1'b0;
			csn_q     <= 1'b1;
			pd_main_q <= 1'b0;
			shift     <= '0;
			bit_cnt   <= '0;
		end
		else
		begin
			sclk_q    <= s_sclk;
			csn_q     <= s_csn;
			pd_main_q <= s_pd_main;
			if (sclk_rise)
			begin
				shift   <= {shift[FRAME_BITS-2:0], serial_bit};
				bit_cnt <= (bit_cnt == 5'h001f) ? bit_cnt : bit_cnt + 5'h0001;
			end
			else if (frame_end)
				bit_cnt <= '0;
		end
	end

	// Control registers, zero from reset so no power-up ordering matters
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pwr_mux  <= PWR_MUX_RESET;
			mod_ctrl <= MOD_CTRL_RESET;
		end
		else
		begin
			if (wr_pwr)
				pwr_mux <= shift[DATA_BITS-1:0];
			if (wr_ctrl)
				mod_ctrl <= shift[DATA_BITS-1:0];
		end
	end

	// Modulation unit: written sample, then unit stage, then main modulator
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pend_sample     <= '0;
			pend_valid      <= 1'b0;
			unit_sample     <= '0;
			unit_valid      <= 1'b0;
			main_mod_offset <= '0;
			main_mod_strobe <= 1'b0;
		end
		else
		begin
			main_mod_strobe <= 1'b0;
			if (pd_fall)
			begin
				unit_valid <= pend_valid;
				if (pend_valid)
					unit_sample <= pend_sample;
				if (unit_valid)
				begin
					main_mod_offset <= scale(unit_sample,
					                         mod_ctrl[MC_MAG_HI:0]);
					main_mod_strobe <= 1'b1;
				end
			end
			// A fresh write wins over the hand-off in the same cycle
			if (wr_data)
			begin
				pend_sample <= $signed(shift[DATA_BITS-1:0]);
				pend_valid  <= 1'b1;
			end
			else if (bare_sample)
			begin
				pend_sample <= sext(shift[DATA_BITS-1:0], bit_cnt);
				pend_valid  <= 1'b1;
			end
			else if (pd_fall)
				pend_valid <= 1'b0;
		end
	end

	// Registered outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link.mux_out     <= 1'b0;
			link.mux_out_oe  <= 1'b0;
			aux_power_down   <= 1'b0;
			aux_integer_mode <= 1'b0;
			main_dsm_ten_bit <= 1'b0;
			main_dsm_width   <= DSM_WIDTH_FULL;
		end
		else
		begin
			link.mux_out     <= next_mux_out;
			link.mux_out_oe  <= !pwr_mux[PM_TRISTATE];
			aux_power_down   <= pwr_mux[PM_AUX_PD];
			aux_integer_mode <= pwr_mux[PM_AUX_INT];
			main_dsm_ten_bit <= pwr_mux[PM_TEN_BIT];
			main_dsm_width   <= pwr_mux[PM_TEN_BIT] ? DSM_WIDTH_TEN
			                                        : DSM_WIDTH_FULL;
		end
	end
endmodule

// file: src/spm_host.sv
`timescale 1ns/1ns
// Host end: APB command registers driving the three-wire write port
module spm_host
	import spm_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	spm_link_if.host         link,
	output logic             busy
);
	typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GAP} spm_hstate_e;

	spm_hstate_e           state;
	logic [3:0]            div;
	logic [FRAME_BITS-1:0] word;
	logic [4:0]            left;
	logic                  use_mod;

	// APB decode
	logic       access;
	logic       hit_cmd;
	logic       hit_status;
	logic       start;
	logic       half_done;
	logic [4:0] cmd_len;

	assign access     = psel && penable && !pready;
	assign hit_cmd    = paddr == HOST_CMD_OFS;
	assign hit_status = paddr == HOST_STATUS_OFS;
	assign cmd_len    = pwdata[CMD_LEN_HI:CMD_LEN_LO];
	assign start      = access && pwrite && hit_cmd && (state == H_IDLE)
	                    && (cmd_len >= 5'(SAMPLE_MIN))
	                    && (cmd_len <= 5'(FRAME_BITS));
	assign half_done  = div == HALF_LAST;

	// APB answer one cycle after the access phase opens
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end
		else
		begin
			pready  <= access;
			pslverr <= access && !hit_cmd && !hit_status;
			prdata  <= (access && !pwrite && hit_status) ? {31'h0000_0000, busy} : '0;
		end
	end

	// Frame sequencer; link clock is a divided pclk, data changes on its fall
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state       <= H_IDLE;
			div         <= '0;
			word        <= '0;
			left        <= '0;
			use_mod     <= 1'b0;
			busy        <= 1'b0;
			link.sclk   <= 1'b0;
			link.csn    <= 1'b1;
			link.sdata  <= 1'b0;
			link.mod_in <= 1'b0;
		end
		else
		begin
			div <= half_done ? 4'h0000 : div + 4'h0001;
			unique case (state)
				H_IDLE:
					if (start)
					begin
						word        <= pwdata[FRAME_BITS-1:0] << (5'(FRAME_BITS) - cmd_len);
						left        <= cmd_len;
						use_mod     <= pwdata[CMD_MODPIN];
						busy        <= 1'b1;
						div         <= '0;
						state       <= H_LOW;
						link.csn    <= 1'b0;
						link.sdata  <= !pwdata[CMD_MODPIN]
						               && pwdata[5'(32'(cmd_len) - 1)];
						link.mod_in <= pwdata[CMD_MODPIN]
						               && pwdata[5'(32'(cmd_len) - 1)];
					end
				H_LOW:
					if (half_done)
					begin
						link.sclk <= 1'b1;
						word      <= word << 1;
						left      <= left - 5'h0001;
						state     <= H_HIGH;
					end
				H_HIGH:
					if (half_done)
					begin
						link.sclk   <= 1'b0;
						link.sdata  <= !use_mod && word[FRAME_BITS-1];
						link.mod_in <= use_mod && word[FRAME_BITS-1];
						state       <= (left == 5'h0000) ? H_TAIL : H_LOW;
					end
				H_TAIL:
					if (half_done)
					begin
						link.csn    <= 1'b1;
						link.sdata  <= 1'b0;
						link.mod_in <= 1'b0;
						state       <= H_GAP;
					end
				H_GAP:
					if (half_done)
					begin
						busy  <= 1'b0;
						state <= H_IDLE;
					end
			endcase
		end
	end
endmodule

// file: tb/spm_asserts.sv
`timescale 1ns/1ns
// Wire checks on the link between host end and device end
module spm_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sclk,
	input wire logic csn,
	input wire logic sdata,
	input wire logic mod_in,
	input wire logic mux_out_oe
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Serial clock phases of one bit
	sequence s_high;
		sclk [*8] ##1 !sclk;
	endsequence
	sequence s_lead;
		!sclk [*8] ##1 sclk;
	endsequence

	// Framing and bit timing on the wire
	property p_idle_low;
		csn |-> !sclk;
	endproperty
	property p_high8;
		$rose(sclk) |-> s_high;
	endproperty
	property p_lead;
		$fell(csn) |-> s_lead;
	endproperty
	property p_data_hold;
		sclk && $past(sclk) |-> $stable(sdata);
	endproperty
	property p_mod_hold;
		sclk && $past(sclk) |-> $stable(mod_in);
	endproperty
	property p_one_pin;
		!(sdata && mod_in);
	endproperty
	property p_gap;
		$rose(csn) |-> csn [*8];
	endproperty
	property p_oe_up;
		$rose(presetn) |-> ##[0:3] mux_out_oe;
	endproperty

	a_idle_low: assert property (p_idle_low)
		else $error("serial clock high outside frame");
	a_high8: assert property (p_high8)
		else $error("serial clock high phase not 8 cycles");
	a_lead: assert property (p_lead)
		else $error("first rise not 8 cycles after select");
	a_data_hold: assert property (p_data_hold)
		else $error("data changed while serial clock high");
	a_mod_hold: assert property (p_mod_hold)
		else $error("alternate pin changed while clock high");
	a_one_pin: assert property (p_one_pin)
		else $error("both data pins high");
	a_gap: assert property (p_gap)
		else $error("select gap shorter than 8 cycles");
	a_oe_up: assert property (p_oe_up)
		else $error("output pin not driven after reset");
endmodule

// file: tb/tb_synth_power_mux_modulation_ctrl.sv
`timescale 1ns/1ns
module tb_synth_power_mux_modulation_ctrl
	import spm_pkg::*;
;
	logic                          pclk;
	logic                          presetn;
	logic                          psel;
	logic                          penable;
	logic                          pwrite;
	logic [11:0]                   paddr;
	logic [31:0]                   pwdata;
	logic [31:0]                   prdata;
	logic                          pready;
	logic                          pslverr;
	logic                          busy;
	logic [4:0]                    src;
	logic                          aux_pd;
	logic                          aux_int;
	logic                          ten_bit;
	logic [4:0]                    width;
	logic signed [OFFSET_BITS-1:0] offset;
	logic                          strobe;
	logic [31:0]                   rd;
	logic                          err;
	int                            strobes = 0;
	int                            highs = 0;
	int                            errors = 0;
	int                            comparisons = 0;
	wire                           mux_pin;

	spm_link_if link ();
	// Pin level as seen off chip
	assign mux_pin = link.mux_out_oe ? link.mux_out : 1'bz;

	spm_host i_spm_host (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.link    (link),
		.busy    (busy)
	);
	spm_device i_spm_device (
		.pclk                      (pclk),
		.presetn                   (presetn),
		.link                      (link),
		.ref_osc                   (src[0]),
		.ref_aux                   (src[1]),
		.ref_main                  (src[2]),
		.aux_phase_detector_clock  (src[3]),
		.main_phase_detector_clock (src[4]),
		.aux_power_down            (aux_pd),
		.aux_integer_mode          (aux_int),
		.main_dsm_ten_bit          (ten_bit),
		.main_dsm_width            (width),
		.main_mod_offset           (offset),
		.main_mod_strobe           (strobe)
	);
	spm_asserts u_chk (
		.pclk       (pclk),
		.presetn    (presetn),
		.sclk       (link.sclk),
		.csn        (link.csn),
		.sdata      (link.sdata),
		.mod_in     (link.mod_in),
		.mux_out_oe (link.mux_out_oe)
	);

	// Clock
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Count modulation hand-overs
	always @(posedge pclk)
		if (strobe === 1'b1)
			strobes <= strobes + 1;

	// Count cycles with the select pin high
	always @(posedge pclk)
		if (mux_pin === 1'b1)
			highs <= highs + 1;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		if (errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// One APB transfer, held until pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// pready ends this wait; the watchdog ends it if pready never comes
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Send one link frame and wait until the host is idle again
	task automatic frame(input logic [15:0] w, input logic [4:0] len, input logic pin);
		apb(1'b1, HOST_CMD_OFS, {7'h00, pin, 3'h0, len, w});
		do
			apb(1'b0, HOST_STATUS_OFS, 32'h0000_0000);
		while (rd[0] !== 1'b0);
		repeat (6) @(posedge pclk);
	endtask

	// One period of the main detector clock, ending on a fall
	task automatic pd_fall();
		@(posedge pclk);
		src[4] <= 1'b1;
		repeat (10) @(posedge pclk);
		src[4] <= 1'b0;
		repeat (10) @(posedge pclk);
	endtask

	// Settings after reset; pin driven and following the oscillator
	task automatic t_reset();
		chk(ten_bit, 0);
		chk(aux_pd, 0);
		chk(aux_int, 0);
		chk(width, DSM_WIDTH_FULL);
		chk(busy, 0);
		chk(32'(offset), 0);
		src <= 5'h01;
		repeat (8) @(posedge pclk);
		chk(mux_pin, 1);
		src <= 5'h00;
		repeat (8) @(posedge pclk);
		chk(mux_pin, 0);
	endtask

	// Ten-bit mode set; low dividend never written
	task automatic t_flags();
		frame({ADDR_PWR_MUX, 12'h0038}, 5'h10, 1'b0);
		chk(ten_bit, 1);
		chk(width, DSM_WIDTH_TEN);
		chk(aux_pd, 1);
		chk(aux_int, 1);
	endtask

	// Each source in turn, loop-back and test pulses, then tri-state
	task automatic t_mux();
		int n;
		for (int c = 0; c < 5; c++)
		begin
			frame({ADDR_PWR_MUX, 12'(c << PM_SEL_LO)}, 5'h10, 1'b0);
			src <= 5'(1 << c);
			repeat (8) @(posedge pclk);
			chk(mux_pin, 1);
			src <= ~5'(1 << c);
			repeat (8) @(posedge pclk);
			chk(mux_pin, 0);
		end
		frame({ADDR_PWR_MUX, 12'h0140}, 5'h10, 1'b0);
		n = highs;
		frame(16'hf0a5, 5'h10, 1'b1);
		chk(highs - n, 128);
		frame({ADDR_PWR_MUX, 12'h0180}, 5'h10, 1'b0);
		n = highs;
		frame(16'hf000, 5'h10, 1'b0);
		chk(highs - n, 16);
		chk(aux_pd, 0);
		chk(aux_int, 0);
		chk(width, DSM_WIDTH_FULL);
		frame({ADDR_PWR_MUX, 12'h0200}, 5'h10, 1'b0);
		chk(mux_pin, 1'bz);
		chk(link.mux_out_oe, 0);
		src <= 5'h00;
	endtask

	// Addressed sample, magnitude 3
	task automatic t_mod();
		int n;
		frame({ADDR_MOD_CTRL, 12'h0003}, 5'h10, 1'b0);
		frame({ADDR_MOD_DATA, 12'hff6}, 5'h10, 1'b0);
		pd_fall();
		n = strobes;
		pd_fall();
		chk(strobes, n + 1);
		chk(32'(offset), 32'(-80));
	endtask

	// Bare 3-bit sample on the alternate pin, magnitude clamped
	task automatic t_bare();
		int n;
		frame({ADDR_MOD_CTRL, 12'h001f}, 5'h10, 1'b0);
		frame(16'h0005, 5'h03, 1'b1);
		pd_fall();
		n = strobes;
		pd_fall();
		chk(strobes, n + 1);
		chk(32'(offset), 32'(-24576));
	endtask

	task automatic t_apb();
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk(err, 1);
		apb(1'b0, HOST_CMD_OFS, 32'h0000_0000);
		chk(rd, 0);
		chk(err, 0);
	endtask

	// Reset in mid-run clears every setting; bare samples refused again
	task automatic t_rerun();
		int n;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		t_reset();
		n = strobes;
		frame(16'h0005, 5'h03, 1'b1);
		pd_fall();
		pd_fall();
		chk(strobes, n);
	endtask

	// Main sequence
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		src = 5'h00;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		t_reset();
		t_flags();
		t_mux();
		t_mod();
		t_bare();
		t_apb();
		t_rerun();
		close_out();
	end

	// Watchdog
	initial
	begin
		#500_000;
		errors++;
		$display("[ERR] %0t run did not finish", $time);
		close_out();
	end
endmodule
